// ===== hw/siw_pkg.sv
// Shared constants and carrier types for the system ident/wakeup/power register group
package siw_pkg;
    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_ID_HI = 8'h00;
    localparam logic [7:0] ADDR_ID_LO = 8'h04;
    localparam logic [7:0] ADDR_WAKE = 8'h08;
    localparam logic [7:0] ADDR_PWR = 8'h0c;
    localparam logic [7:0] ADDR_PEND = 8'h10;

    // Wakeup timer status/control fields
    localparam int W_FLAG = 7;
    localparam int W_ACK = 6;
    localparam int W_CLKS = 5;
    localparam int W_IE = 4;
    localparam int W_SEL_LSB = 0;
    localparam int W_SEL_W = 3;

    // Power monitor status/control fields
    localparam int P_FLAG = 7;
    localparam int P_ACK = 6;
    localparam int P_IE = 5;
    localparam int P_RE = 4;
    localparam int P_SE = 3;
    localparam int P_EN = 2;
    localparam int P_BUF = 0;

    // Pending status fields
    localparam int PEND_BRN = 7;
    localparam int PEND_WAKE = 0;

    // Reset values of the writable registers
    localparam logic [7:0] WAKE_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;

    // Wakeup periods, in 1 kHz ticks (ms) and in external clock periods
    localparam logic [7:0][15:0] INT_PERIOD_MS = {
        16'h0400, 16'h0200, 16'h0100, 16'h0080,
        16'h0040, 16'h0020, 16'h0008, 16'h0000};
    localparam logic [7:0][15:0] EXT_PERIOD_CYC = {
        16'h8000, 16'h4000, 16'h2000, 16'h1000,
        16'h0800, 16'h0400, 16'h0100, 16'h0000};

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } siw_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } siw_apb_rsp_t;
endpackage

// ===== hw/siw_regs.sv
// System ident, periodic wakeup timer and power monitor register group
//
// Operation
// - Ident high upper nibble returns fixed silicon revision; writes ignored.
// - Fixed 12-bit part number: upper four in high low nibble, rest low.
// - Wakeup flag bit 7 is read-only, set when period elapses.
// - Writing one to bit 6 clears wakeup flag; reads zero.
// - Bit 5 picks timer source: 0 internal 1 kHz, 1 external.
// - Bit 4 gates the wakeup interrupt request while flag is set.
// - Period select 000 stops and clears the wakeup counter.
// - Internal source codes 1..7 give 8..1024 ms timeouts.
// - External source codes 1..7 give 256..32768 external periods.
// - Brownout flag bit 7 read-only, reports events only while enabled.
// - Writing one to bit 6 clears brownout flag; reads zero.
// - Brownout interrupt enable bit 5 raises request while flag set.
// - Write-once bit 4 forces device reset when flag sets and enabled.
// - Bit 3 keeps brownout detection running in stop mode.
// - Write-once bit 2 enables brownout logic and its other bits.
// - Each write-once bit takes one write after reset; later ignored.
// - Bit 0 of power register enables the reference buffer.
// - Wakeup pending follows wakeup flag; clears on ack and reset.
// - Brownout pending clears on brownout ack and on reset.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module siw_regs #(
    parameter logic [3:0] REVISION = 4'h0, // Arbitrary value
    parameter logic [11:0] PART_NUMBER = 12'h5a3 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire siw_pkg::siw_apb_req_t apb_req,
    output siw_pkg::siw_apb_rsp_t apb_rsp_r,
    // Timer sources, one-cycle ticks
    input wire logic tick_1khz,
    input wire logic ext_clk_tick,
    // Power monitor inputs
    input wire logic brownout_detect,
    input wire logic stop_mode,
    // Outputs to the system
    output logic wakeup_irq_r,
    output logic brownout_irq_r,
    output logic brownout_reset_r,
    output logic brownout_detector_on_r,
    output logic reference_buffer_enable_r
);
    // Bus decode
    logic access;
    logic hit;
    logic wr_fire;
    logic wr_wake;
    logic wr_pwr;
    logic [7:0] rd_mux;

    // Wakeup timer state
    logic wake_flag_r;
    logic wake_clks_r;
    logic wake_ie_r;
    logic [2:0] wake_sel_r;
    logic [3:0] cfg_prev_r;
    logic [15:0] cnt_r;
    logic [15:0] period;
    logic tick;
    logic cfg_chg;
    logic elapse;

    // Power monitor state
    logic brn_flag_r;
    logic brn_ie_r;
    logic brn_se_r;
    logic buf_en_r;
    logic [1:0] wo_val_r;
    logic [1:0] wo_used_r;
    logic brn_en;
    logic brn_re;
    logic brn_active;
    logic brn_set;

    // Access phase and write strobes
    assign access = apb_req.psel & apb_req.penable;
    assign wr_fire = access & apb_rsp_r.pready & apb_req.pwrite & hit;
    assign wr_wake = wr_fire & (apb_req.paddr == siw_pkg::ADDR_WAKE);
    assign wr_pwr = wr_fire & (apb_req.paddr == siw_pkg::ADDR_PWR);

    // Write-once bit aliases
    assign brn_re = wo_val_r[0];
    assign brn_en = wo_val_r[1];

    // Read data mux, acks read as zero
    always_comb
    begin
        hit = 1'b1;
        rd_mux = 8'h00;
        case (apb_req.paddr)
            siw_pkg::ADDR_ID_HI:
            begin
                rd_mux = {REVISION, PART_NUMBER[11:8]};
            end
            siw_pkg::ADDR_ID_LO:
            begin
                rd_mux = PART_NUMBER[7:0];
            end
            siw_pkg::ADDR_WAKE:
            begin
                rd_mux[siw_pkg::W_FLAG] = wake_flag_r;
                rd_mux[siw_pkg::W_CLKS] = wake_clks_r;
                rd_mux[siw_pkg::W_IE] = wake_ie_r;
                rd_mux[siw_pkg::W_SEL_LSB +: siw_pkg::W_SEL_W] = wake_sel_r;
            end
            siw_pkg::ADDR_PWR:
            begin
                rd_mux[siw_pkg::P_FLAG] = brn_flag_r;
                rd_mux[siw_pkg::P_IE] = brn_ie_r;
                rd_mux[siw_pkg::P_RE] = brn_re;
                rd_mux[siw_pkg::P_SE] = brn_se_r;
                rd_mux[siw_pkg::P_EN] = brn_en;
                rd_mux[siw_pkg::P_BUF] = buf_en_r;
            end
            siw_pkg::ADDR_PEND:
            begin
                rd_mux[siw_pkg::PEND_BRN] = brn_flag_r;
                rd_mux[siw_pkg::PEND_WAKE] = wake_flag_r;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // APB answer: one wait state, read data captured with pready
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            apb_rsp_r <= '0;
        end
        else
        begin
            apb_rsp_r.pready <= access & ~apb_rsp_r.pready;
            if (access & ~apb_rsp_r.pready)
            begin
                apb_rsp_r.prdata <= {24'h000000, rd_mux};
                apb_rsp_r.pslverr <= ~hit;
            end
        end
    end

    // Wakeup timer control bits
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wake_clks_r <= siw_pkg::WAKE_RST[siw_pkg::W_CLKS];
            wake_ie_r <= siw_pkg::WAKE_RST[siw_pkg::W_IE];
            wake_sel_r <= siw_pkg::WAKE_RST[siw_pkg::W_SEL_LSB +: siw_pkg::W_SEL_W];
        end
        else if (wr_wake)
        begin
            wake_clks_r <= apb_req.pwdata[siw_pkg::W_CLKS];
            wake_ie_r <= apb_req.pwdata[siw_pkg::W_IE];
            wake_sel_r <= apb_req.pwdata[siw_pkg::W_SEL_LSB +: siw_pkg::W_SEL_W];
        end
    end

    // Source and period selection
    assign tick = wake_clks_r ? ext_clk_tick : tick_1khz;
    assign period = wake_clks_r ? siw_pkg::EXT_PERIOD_CYC[wake_sel_r]
        : siw_pkg::INT_PERIOD_MS[wake_sel_r];
    assign cfg_chg = cfg_prev_r != {wake_clks_r, wake_sel_r};
    assign elapse = (wake_sel_r != 3'h0) & ~cfg_chg & tick
        & ((cnt_r + 16'h0001) == period);

    // Wakeup counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 16'h0000;
            cfg_prev_r <= 4'h0;
        end
        else
        begin
            cfg_prev_r <= {wake_clks_r, wake_sel_r};
            if ((wake_sel_r == 3'h0) | cfg_chg)
            begin
                cnt_r <= 16'h0000;
            end
            else if (elapse)
            begin
                cnt_r <= 16'h0000;
            end
            else if (tick)
            begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // Wakeup flag, a timeout wins over a same-cycle ack
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wake_flag_r <= 1'b0;
        end
        else if (elapse)
        begin
            wake_flag_r <= 1'b1;
        end
        else if (wr_wake & apb_req.pwdata[siw_pkg::W_ACK])
        begin
            wake_flag_r <= 1'b0;
        end
    end

    // Wakeup interrupt request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wakeup_irq_r <= 1'b0;
        end
        else
        begin
            wakeup_irq_r <= wake_flag_r & wake_ie_r;
        end
    end

    // Write-once bits: reset enable and detection enable
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_wo
            localparam int B = (i == 0) ? siw_pkg::P_RE : siw_pkg::P_EN;
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    wo_val_r[i] <= siw_pkg::PWR_RST[B];
                    wo_used_r[i] <= 1'b0;
                end
                else if (wr_pwr & ~wo_used_r[i])
                begin
                    wo_val_r[i] <= apb_req.pwdata[B];
                    wo_used_r[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // Plain read/write power monitor bits
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            brn_ie_r <= siw_pkg::PWR_RST[siw_pkg::P_IE];
            brn_se_r <= siw_pkg::PWR_RST[siw_pkg::P_SE];
            buf_en_r <= siw_pkg::PWR_RST[siw_pkg::P_BUF];
        end
        else if (wr_pwr)
        begin
            brn_ie_r <= apb_req.pwdata[siw_pkg::P_IE];
            brn_se_r <= apb_req.pwdata[siw_pkg::P_SE];
            buf_en_r <= apb_req.pwdata[siw_pkg::P_BUF];
        end
    end

    // Detection runs when enabled, and in stop mode only if allowed
    assign brn_active = brn_en & (~stop_mode | brn_se_r);
    assign brn_set = brn_active & brownout_detect;

    // Brownout flag, a new event wins over a same-cycle ack
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            brn_flag_r <= 1'b0;
        end
        else if (brn_set)
        begin
            brn_flag_r <= 1'b1;
        end
        else if ((wr_pwr & apb_req.pwdata[siw_pkg::P_ACK]) | ~brn_en)
        begin
            brn_flag_r <= 1'b0;
        end
    end

    // Brownout outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            brownout_irq_r <= 1'b0;
            brownout_reset_r <= 1'b0;
            brownout_detector_on_r <= 1'b0;
            reference_buffer_enable_r <= 1'b0;
        end
        else
        begin
            brownout_irq_r <= brn_flag_r & brn_ie_r & brn_en;
            brownout_reset_r <= brn_flag_r & brn_re & brn_en;
            brownout_detector_on_r <= brn_active;
            reference_buffer_enable_r <= buf_en_r;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_id_read;
        access && !apb_rsp_r.pready && apb_req.paddr == siw_pkg::ADDR_ID_HI;
    endsequence

    sequence s_wo_rewrite;
        wr_pwr && wo_used_r[0];
    endsequence

    sequence s_wake_last_tick;
        tick && wake_sel_r != 3'h0 && !cfg_chg && cnt_r == period - 16'h0001;
    endsequence

    a_id_high_value: assert property (
        s_id_read |=> apb_rsp_r.pready
            && apb_rsp_r.prdata == {24'h000000, REVISION, PART_NUMBER[11:8]})
        else $error("ident high read wrong");

    a_wake_ack_clears: assert property (
        wr_wake && apb_req.pwdata[siw_pkg::W_ACK] && !elapse |=> !wake_flag_r)
        else $error("wakeup ack did not clear flag");

    a_ack_reads_zero: assert property (
        access && !apb_rsp_r.pready && (apb_req.paddr == siw_pkg::ADDR_WAKE
            || apb_req.paddr == siw_pkg::ADDR_PWR) |=> !apb_rsp_r.prdata[6])
        else $error("ack bit read as one");

    a_sel_zero_held: assert property (
        wake_sel_r == 3'h0 |=> cnt_r == 16'h0000 && !$rose(wake_flag_r))
        else $error("counter ran while stopped");

    a_period_sets_flag: assert property (
        s_wake_last_tick |=> wake_flag_r && cnt_r == 16'h0000)
        else $error("period end did not set flag");

    a_wake_irq_gate: assert property (
        wake_flag_r && wake_ie_r |=> wakeup_irq_r)
        else $error("wakeup request not raised");

    a_wake_irq_off: assert property (
        !wake_ie_r |=> !wakeup_irq_r)
        else $error("wakeup request while disabled");

    a_brn_needs_en: assert property (
        !brn_en |=> !brn_flag_r && !brownout_reset_r)
        else $error("brownout flag while disabled");

    a_brn_reset_force: assert property (
        brn_flag_r && brn_re && brn_en |=> brownout_reset_r)
        else $error("brownout reset missing");

    a_brn_stop_gate: assert property (
        !brn_flag_r && stop_mode && !brn_se_r |=> !brn_flag_r)
        else $error("brownout set in stop mode");

    a_write_once_hold: assert property (
        s_wo_rewrite |=> $stable(wo_val_r[0]) && $stable(wo_val_r[1]))
        else $error("write-once bit changed twice");

    a_brn_irq_gate: assert property (
        brn_flag_r && brn_ie_r && brn_en |=> brownout_irq_r)
        else $error("brownout request missing");
endmodule

// ===== verification/siw_regs_tb.sv
// Self-checking testbench for the ident, wakeup timer and power monitor registers
`timescale 1ns/10ps
module siw_regs_tb;
    localparam logic [3:0] REV = 4'h3; // Arbitrary value
    localparam logic [11:0] PART = 12'h9c4; // Arbitrary value
    logic clk;
    logic rst;
    siw_pkg::siw_apb_req_t req;
    siw_pkg::siw_apb_rsp_t rsp;
    logic tick_1khz;
    logic ext_clk_tick;
    logic brownout_detect;
    logic stop_mode;
    logic wake_irq;
    logic brn_irq;
    logic brn_rst;
    logic brn_on;
    logic ref_buf;
    int bad_count;
    int checks;

    siw_regs #(.REVISION(REV), .PART_NUMBER(PART)) i_siw_regs (
        .clk(clk),
        .rst(rst),
        .apb_req(req),
        .apb_rsp_r(rsp),
        .tick_1khz(tick_1khz),
        .ext_clk_tick(ext_clk_tick),
        .brownout_detect(brownout_detect),
        .stop_mode(stop_mode),
        .wakeup_irq_r(wake_irq),
        .brownout_irq_r(brn_irq),
        .brownout_reset_r(brn_rst),
        .brownout_detector_on_r(brn_on),
        .reference_buffer_enable_r(ref_buf)
    );

    // Clock at 200 MHz
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        q = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 50)
            chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    // One-cycle pulses of the chosen timer source
    task automatic ticks(input bit ext, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (ext)
                ext_clk_tick <= 1'b1;
            else
                tick_1khz <= 1'b1;
            @(posedge clk);
            ext_clk_tick <= 1'b0;
            tick_1khz <= 1'b0;
        end
    endtask

    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // Ident values, ignored writes and an unmapped address
    task automatic t_ident();
        logic [31:0] q;
        logic e;
        rd(8'h00, {24'h0, REV, PART[11:8]});
        rd(8'h04, {24'h0, PART[7:0]});
        wr(8'h00, 32'hff);
        wr(8'h04, 32'hff);
        rd(8'h00, {24'h0, REV, PART[11:8]});
        rd(8'h04, {24'h0, PART[7:0]});
        xfer(1'b0, 8'h14, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask

    // Every internal period code, flag one tick early and on time
    task automatic t_wake_int();
        int per[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
        for (int c = 1; c < 8; c++)
        begin
            wr(8'h08, 32'h50 | c);
            ticks(1'b0, per[c] - 1);
            rd(8'h08, 32'h10 | c);
            ticks(1'b0, 1);
            rd(8'h08, 32'h90 | c);
            chk({31'h0, wake_irq}, 32'h1);
            rd(8'h10, 32'h01);
        end
        wr(8'h08, 32'h57);
        rd(8'h08, 32'h17);
        rd(8'h10, 32'h00);
        chk({31'h0, wake_irq}, 32'h0);
    endtask

    // External source, irq gated off, stopped counter
    task automatic t_wake_ext();
        wr(8'h08, 32'h61);
        ticks(1'b0, 300);
        rd(8'h08, 32'h21);
        ticks(1'b1, 255);
        rd(8'h08, 32'h21);
        ticks(1'b1, 1);
        rd(8'h08, 32'ha1);
        chk({31'h0, wake_irq}, 32'h0);
        wr(8'h08, 32'h62);
        ticks(1'b1, 1023);
        rd(8'h08, 32'h22);
        ticks(1'b1, 1);
        rd(8'h08, 32'ha2);
        wr(8'h08, 32'h60);
        ticks(1'b1, 300);
        rd(8'h08, 32'h20);
    endtask

    // Detection locked off by the first write
    task automatic t_brn_off();
        wr(8'h08, 32'h80);
        rd(8'h08, 32'h00);
        rd(8'h0c, 32'h00);
        wr(8'h0c, 32'h80);
        brownout_detect <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h0c, 32'h00);
        wr(8'h0c, 32'h04);
        rd(8'h0c, 32'h00);
        chk({31'h0, brn_on}, 32'h0);
        brownout_detect <= 1'b0;
    endtask

    // Detection on: flag, irq, reset, stop mode, buffer, ack
    task automatic t_brn_on();
        wr(8'h0c, 32'h3d);
        brownout_detect <= 1'b1;
        rd(8'h0c, 32'hbd);
        chk({28'h0, brn_irq, brn_rst, brn_on, ref_buf}, 32'hf);
        rd(8'h10, 32'h80);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, brn_on}, 32'h1);
        wr(8'h0c, 32'h00);
        rd(8'h0c, 32'h94);
        chk({28'h0, brn_irq, brn_rst, brn_on, ref_buf}, 32'h4);
        wr(8'h0c, 32'h40);
        rd(8'h0c, 32'h14);
        rd(8'h10, 32'h00);
        chk({31'h0, brn_rst}, 32'h0);
        stop_mode <= 1'b0;
        rd(8'h0c, 32'h94);
        brownout_detect <= 1'b0;
        wr(8'h0c, 32'h40);
        rd(8'h0c, 32'h14);
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        req = '0;
        tick_1khz = 1'b0;
        ext_clk_tick = 1'b0;
        brownout_detect = 1'b0;
        stop_mode = 1'b0;
        bad_count = 0;
        checks = 0;
        reset_dut();
        t_brn_off();
        t_ident();
        t_wake_int();
        t_wake_ext();
        reset_dut();
        rd(8'h00, {24'h0, REV, PART[11:8]});
        t_brn_on();
        tally_and_finish();
    end
endmodule
